/* hdl/xpd_pkg.sv */
// Constants for the XOR and port direction execution block.
// Assumes a core that presents one 12-bit instruction per issue strobe.
// Summary of operation
// - Direction load decoded from fixed upper bits; only target 6 is accepted.
// - Direction load copies accumulator into port direction; flags untouched.
// - Literal XOR decoded from top nibble 1111; literal XORed with accumulator.
// - Literal XOR result replaces the accumulator.
// - Register XOR decoded from 000110; XORs accumulator with addressed file.
// - Destination bit set: result to file register, accumulator untouched.
package xpd_pkg;
	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [8:0]  DIR_LOAD_TOP   = 9'h000;
	localparam logic [2:0]  DIR_TARGET_IO  = 3'h6;
	localparam logic [3:0]  XLIT_TOP       = 4'hf;
	localparam logic [5:0]  XFILE_TOP      = 6'h06;
	localparam int          DEST_BIT       = 5;
	// ------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------
	localparam int          FILE_DEPTH     = 32;
	localparam logic [7:0]  ACC_RESET      = 8'h00;
	localparam logic [7:0]  DIR_RESET      = 8'hff;
	typedef enum logic [1:0] {XPD_OP_NONE, XPD_OP_DIR, XPD_OP_XLIT, XPD_OP_XFILE} xpd_op_t;
endpackage : xpd_pkg

/* hdl/xpd_file_if.sv */
// Interface between executor and its file register memory.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface xpd_file_if;
	logic [4:0] raddr;
	logic [7:0] rdata;
	logic       we;
	logic [4:0] waddr;
	logic [7:0] wdata;
	modport exec (output raddr, input rdata, output we, output waddr, output wdata);
	modport mem  (input raddr, output rdata, input we, input waddr, input wdata);
endinterface : xpd_file_if

/* hdl/xpd_file_mem.sv */
// File register array, 32 x 8, registered read data.
// Assumes read address is presented one cycle before data is used.
`timescale 1ns/1ps
module xpd_file_mem
	import xpd_pkg::*;
(
	input  wire logic   mclk,
	xpd_file_if.mem     fif
);
	logic [7:0] mem [0:FILE_DEPTH-1];
	always_ff @(posedge mclk)
	begin
		if (fif.we)
		begin
			mem[fif.waddr] <= fif.wdata;
		end
	end
	// Write-through so a back-to-back read sees fresh data
	always_ff @(posedge mclk)
	begin
		if (fif.we && fif.waddr == fif.raddr)
		begin
			fif.rdata <= fif.wdata;
		end
		else
		begin
			fif.rdata <= mem[fif.raddr];
		end
	end
endmodule : xpd_file_mem

/* hdl/xpd_exec.sv */
// Executes direction load, literal XOR and register XOR instructions.
// Assumes issue pulses are at least two cycles apart (fetch, execute).
`timescale 1ns/1ps
module xpd_exec
	import xpd_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        issue,
	input  wire logic [11:0] instr,
	input  wire logic        file_wr,
	input  wire logic [4:0]  file_wr_addr,
	input  wire logic [7:0]  file_wr_data,
	output logic [7:0]       acc,
	output logic [7:0]       port_dir,
	output logic             zero_flag,
	output logic             done,
	output logic             illegal
);
	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	xpd_op_t     op;
	xpd_op_t     pend_op;
	logic [11:0] pend_instr;
	logic [7:0]  result;
	xpd_file_if  fif();

	always_comb
	begin
		op = XPD_OP_NONE;
		if (instr[11:3] == DIR_LOAD_TOP && instr[2:0] == DIR_TARGET_IO)
			op = XPD_OP_DIR;
		else if (instr[11:8] == XLIT_TOP)
			op = XPD_OP_XLIT;
		else if (instr[11:6] == XFILE_TOP)
			op = XPD_OP_XFILE;
	end

	// Operand fetch cycle, then execute; one instruction cycle each
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pend_op    <= XPD_OP_NONE;
			pend_instr <= 12'h000;
			illegal    <= 1'b0;
		end
		else
		begin
			pend_op    <= issue ? op : XPD_OP_NONE;
			pend_instr <= instr;
			illegal    <= issue && op == XPD_OP_NONE;
		end
	end

	assign fif.raddr = instr[4:0];

	always_comb
	begin
		case (pend_op)
			XPD_OP_XLIT:  result = acc ^ pend_instr[7:0];
			XPD_OP_XFILE: result = acc ^ fif.rdata;
			default:      result = acc;
		endcase
	end

	// ------------------------------------------------------------
	// Architectural state
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			acc <= ACC_RESET;
		else if (pend_op == XPD_OP_XLIT)
			acc <= result;
		else if (pend_op == XPD_OP_XFILE && !pend_instr[DEST_BIT])
			acc <= result;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			port_dir <= DIR_RESET;
		else if (pend_op == XPD_OP_DIR)
			port_dir <= acc;
	end

	// Direction load leaves the flag alone
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			zero_flag <= 1'b0;
		else if (pend_op == XPD_OP_XLIT || pend_op == XPD_OP_XFILE)
			zero_flag <= (result == 8'h00);
	end

	assign done = pend_op != XPD_OP_NONE;

	// Core writes have lower priority than our own write-back
	always_comb
	begin
		fif.we    = file_wr;
		fif.waddr = file_wr_addr;
		fif.wdata = file_wr_data;
		if (pend_op == XPD_OP_XFILE && pend_instr[DEST_BIT])
		begin
			fif.we    = 1'b1;
			fif.waddr = pend_instr[4:0];
			fif.wdata = result;
		end
	end

	xpd_file_mem u_mem (
		.mclk (mclk),
		.fif  (fif)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// Port direction takes the accumulator seen in the execute cycle
	a_dir_load_copy: assert property (
		issue && op == XPD_OP_DIR
		|=> ##0 done ##1 port_dir == $past(acc, 1))
		else $error("port dir not loaded");

	a_dir_keeps_z: assert property (
		pend_op == XPD_OP_DIR
		|=> zero_flag == $past(zero_flag))
		else $error("dir load changed flag");

	a_dir_keeps_acc: assert property (
		pend_op == XPD_OP_DIR
		|=> acc == $past(acc))
		else $error("dir load changed acc");

	a_port_dir_held: assert property (
		pend_op != XPD_OP_DIR
		|=> port_dir == $past(port_dir))
		else $error("port dir changed without load");

	a_dir_bad_target: assert property (
		issue && instr[11:3] == DIR_LOAD_TOP && instr[2:0] != DIR_TARGET_IO
		|=> illegal && !done)
		else $error("bad target accepted");

	a_illegal_no_done: assert property (
		illegal
		|-> !done)
		else $error("refused word executed");

	a_xlit_decode: assert property (
		issue && instr[11:8] == XLIT_TOP
		|=> done && !illegal)
		else $error("literal xor not decoded");

	// Literal sampled at issue, two edges before the result is visible
	a_xlit_result: assert property (
		issue && op == XPD_OP_XLIT
		|=> ##1 acc == ($past(acc, 1) ^ $past(instr[7:0], 2)))
		else $error("literal xor wrong");

	a_xlit_no_write: assert property (
		pend_op == XPD_OP_XLIT
		|-> fif.we == file_wr)
		else $error("literal xor wrote file");

	a_xfile_decode: assert property (
		issue && instr[11:6] == XFILE_TOP
		|=> done && !illegal)
		else $error("register xor not decoded");

	a_xfile_we: assert property (
		pend_op == XPD_OP_XFILE && pend_instr[DEST_BIT]
		|-> fif.we && fif.wdata == (acc ^ fif.rdata))
		else $error("file write-back wrong");

	a_xfile_to_acc: assert property (
		pend_op == XPD_OP_XFILE && !pend_instr[DEST_BIT]
		|-> !fif.we || file_wr)
		else $error("file written for d=0");

	a_xfile_acc_upd: assert property (
		issue && op == XPD_OP_XFILE && !instr[DEST_BIT]
		|=> ##1 acc == ($past(acc, 1) ^ $past(fif.rdata, 1)))
		else $error("acc not loaded for d=0");

	a_xfile_to_file: assert property (
		pend_op == XPD_OP_XFILE && pend_instr[DEST_BIT]
		|=> acc == $past(acc))
		else $error("acc changed for d=1");

	a_xfile_waddr: assert property (
		issue && op == XPD_OP_XFILE && instr[DEST_BIT]
		|=> fif.we && fif.waddr == $past(instr[4:0]))
		else $error("write-back address wrong");

	// Flag follows the XOR value itself, whichever destination gets it
	a_zero_flag: assert property (
		(pend_op == XPD_OP_XLIT || pend_op == XPD_OP_XFILE)
		|=> zero_flag == ($past(acc ^ (pend_op == XPD_OP_XLIT ?
			pend_instr[7:0] : fif.rdata)) == 8'h00))
		else $error("zero flag wrong");

	a_flag_idle: assert property (
		pend_op == XPD_OP_NONE
		|=> zero_flag == $past(zero_flag))
		else $error("flag changed while idle");

	a_single_cycle: assert property (
		issue && op != XPD_OP_NONE
		|=> done ##1 (!done || $past(issue)))
		else $error("not single cycle");

	a_no_stray_done: assert property (
		!issue
		|=> !done)
		else $error("done without issue");

	// ------------------------------------------------------------
	// Coverage
	// ------------------------------------------------------------
	c_dir:   cover property (pend_op == XPD_OP_DIR);
	c_xlit0: cover property (pend_op == XPD_OP_XLIT ##1 zero_flag);
	c_xf_d0: cover property (pend_op == XPD_OP_XFILE && !pend_instr[DEST_BIT]);
	c_xf_d1: cover property (pend_op == XPD_OP_XFILE && pend_instr[DEST_BIT]);
	c_illegal: cover property (illegal);
endmodule : xpd_exec

/* dv/xpd_exec_tb.sv */
// Self-checking bench for the XOR and port direction executor.
// Assumes the file array sits inside xpd_exec; bench drives all ports.
`timescale 1ns/1ps
module xpd_exec_tb;
	import xpd_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic        mclk         = 1'b0;
	logic        arst_n       = 1'b0;
	logic        issue        = 1'b0;
	logic [11:0] instr        = 12'h000;
	logic        file_wr      = 1'b0;
	logic [4:0]  file_wr_addr = 5'h00;
	logic [7:0]  file_wr_data = 8'h00;
	logic [7:0]  acc;
	logic [7:0]  port_dir;
	logic        zero_flag;
	logic        done;
	logic        illegal;
	int          num_errors   = 0;
	int          samples_checked = 0;
	always #2.5 mclk = ~mclk;
	xpd_exec xpd_exec_inst (.mclk(mclk), .arst_n(arst_n), .issue(issue), .instr(instr),
		.file_wr(file_wr), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
		.acc(acc), .port_dir(port_dir), .zero_flag(zero_flag), .done(done),
		.illegal(illegal));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Issue, check the one-cycle answer, then let state land
	task automatic run(input logic [11:0] w, input logic bad);
		@(posedge mclk) #1;
		issue = 1'b1;
		instr = w;
		@(posedge mclk) #1;
		issue = 1'b0;
		chk("done", {7'h00, !bad}, {7'h00, done});
		chk("illegal", {7'h00, bad}, {7'h00, illegal});
		@(posedge mclk) #1;
	endtask : run
	task automatic state(input logic [7:0] a, input logic [7:0] p, input logic z);
		chk("acc", a, acc);
		chk("port_dir", p, port_dir);
		chk("zero_flag", {7'h00, z}, {7'h00, zero_flag});
	endtask : state
	task automatic fwrite(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk) #1;
		file_wr = 1'b1;
		file_wr_addr = a;
		file_wr_data = d;
		@(posedge mclk) #1;
		file_wr = 1'b0;
	endtask : fwrite
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_xlit;
		state(ACC_RESET, DIR_RESET, 1'b0);
		run(12'hfaf, 1'b0);
		state(8'haf, DIR_RESET, 1'b0);
		run(12'hf1a, 1'b0);
		state(8'hb5, DIR_RESET, 1'b0);
		run(12'hfb5, 1'b0);
		state(8'h00, DIR_RESET, 1'b1);
	endtask : t_xlit
	task automatic t_dir;
		run(12'h006, 1'b0);
		state(8'h00, 8'h00, 1'b1);
		run(12'hfa5, 1'b0);
		run(12'h006, 1'b0);
		state(8'ha5, 8'ha5, 1'b0);
		run(12'h005, 1'b1);
		state(8'ha5, 8'ha5, 1'b0);
	endtask : t_dir
	task automatic t_xfile;
		fwrite(5'h1f, 8'haf);
		fwrite(5'h00, 8'ha5);
		run(12'h1bf, 1'b0);
		state(8'ha5, 8'ha5, 1'b0);
		run(12'h19f, 1'b0);
		state(8'haf, 8'ha5, 1'b0);
		run(12'h19f, 1'b0);
		state(8'ha5, 8'ha5, 1'b0);
		run(12'h1a0, 1'b0);
		state(8'ha5, 8'ha5, 1'b1);
		run(12'h180, 1'b0);
		state(8'ha5, 8'ha5, 1'b0);
	endtask : t_xfile
	task automatic wrap_up;
		if (num_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge mclk);
		#1 arst_n = 1'b1;
		t_xlit();
		t_dir();
		t_xfile();
		wrap_up();
	end
	// Whole run is about 46 cycles; allow ample margin
	initial
	begin
		#5000;
		num_errors++;
		wrap_up();
	end
endmodule : xpd_exec_tb
